// >>> bfo_defines.vh
`ifndef BFO_DEFINES_VH
`define BFO_DEFINES_VH

// Operation codes presented by decode
`define BFO_OP_NOP 5'h00
`define BFO_OP_LSL 5'h01
`define BFO_OP_LSR 5'h02
`define BFO_OP_ROL 5'h03
`define BFO_OP_ROR 5'h04
`define BFO_OP_ASR 5'h05
`define BFO_OP_SWAP 5'h06
`define BFO_OP_SBI 5'h07
`define BFO_OP_CBI 5'h08
`define BFO_OP_BST 5'h09
`define BFO_OP_BLD 5'h0A
`define BFO_OP_BSET 5'h0B
`define BFO_OP_BCLR 5'h0C
`define BFO_OP_BREAK 5'h0D
`define BFO_OP_SLEEP 5'h0E
`define BFO_OP_WDR 5'h0F
`define BFO_OP_MEM 5'h10

// Status flag bit positions
`define BFO_FLAG_C 3'h0
`define BFO_FLAG_Z 3'h1
`define BFO_FLAG_N 3'h2
`define BFO_FLAG_V 3'h3
`define BFO_FLAG_S 3'h4
`define BFO_FLAG_H 3'h5
`define BFO_FLAG_T 3'h6
`define BFO_FLAG_I 3'h7

`define BFO_FLAGS_RESET 8'h00
`define BFO_NVM_EXTRA_MIN 4'h1

`endif

// >>> bfo_core.v
`timescale 1ns/1ps
`include "bfo_defines.vh"

// What this block does
// - Break takes one cycle, flags untouched
// - Half-carry set or clear in one cycle
// - Listed memory timing applies to internal RAM
// - Nonvolatile access adds at least one cycle
// - Nonvolatile access stalls while busy or contended
module bfo_core #(
	// Extra wait cycles for a nonvolatile access, never below one
	parameter [3:0] NVM_EXTRA = `BFO_NVM_EXTRA_MIN
) (
	// Clock and control
	input wire clk,
	input wire srst,
	input wire ce,
	// Decoded instruction
	input wire op_valid,
	input wire [4:0] op_code,
	input wire [7:0] op_data,
	input wire [2:0] op_bit,
	input wire mem_is_nvm,
	// Nonvolatile memory controller status
	input wire nvm_busy,
	input wire nvm_contend,
	// Handshake
	output wire op_ready,
	// Results
	output reg [7:0] result_r,
	output reg result_we_r,
	output reg [7:0] status_flags_register_r,
	output reg mem_done_r,
	// Unit signals, one-cycle pulses
	output reg break_req_r,
	output reg sleep_req_r,
	output reg wdr_req_r
);

	localparam ST_IDLE = 1'b0;
	localparam ST_NVM = 1'b1;

	reg state_r;
	reg [3:0] wait_cnt_r;
	reg [7:0] res_nxt;
	reg [7:0] flg_nxt;
	reg we_nxt;
	reg cz;

	wire take = ce && op_valid && op_ready;

	// A new op is only accepted when no nonvolatile access is outstanding
	// Limitation: decode must hold the op itself while this is low
	assign op_ready = (state_r == ST_IDLE);

	// Accepted op of one given code
	function hit;
		input t;
		input [4:0] code;
		input [4:0] want;
		begin
			hit = t && (code == want);
		end
	endfunction

	// Single-bit write shared by the I/O, T-load and flag ops
	function [7:0] bit_put;
		input [7:0] v;
		input [2:0] i;
		input b;
		reg [7:0] t;
		begin
			t = v;
			t[i] = b;
			bit_put = t;
		end
	endfunction

	function [7:0] zn_fix;
		input [7:0] f;
		input [7:0] r;
		input c;
		input v;
		reg [7:0] t;
		begin
			t = f;
			t[`BFO_FLAG_C] = c;
			t[`BFO_FLAG_Z] = (r == 8'h00);
			t[`BFO_FLAG_N] = r[7];
			t[`BFO_FLAG_V] = v;
			t[`BFO_FLAG_S] = r[7] ^ v;
			zn_fix = t;
		end
	endfunction

	always @* begin
		res_nxt = op_data;
		flg_nxt = status_flags_register_r;
		we_nxt = 1'b0;
		// Carry in is the flag as it stood before this op
		cz = status_flags_register_r[`BFO_FLAG_C];
		// Unknown codes fall through as no-operation
		case (op_code)
			// Shifts and rotates
			`BFO_OP_LSL: begin
				res_nxt = {op_data[6:0], 1'b0};
				flg_nxt = zn_fix(flg_nxt, res_nxt, op_data[7], res_nxt[7] ^ op_data[7]);
				flg_nxt[`BFO_FLAG_H] = op_data[3];
				we_nxt = 1'b1;
			end
			`BFO_OP_ROL: begin
				res_nxt = {op_data[6:0], cz};
				flg_nxt = zn_fix(flg_nxt, res_nxt, op_data[7], res_nxt[7] ^ op_data[7]);
				flg_nxt[`BFO_FLAG_H] = op_data[3];
				we_nxt = 1'b1;
			end
			`BFO_OP_LSR: begin
				res_nxt = {1'b0, op_data[7:1]};
				flg_nxt = zn_fix(flg_nxt, res_nxt, op_data[0], op_data[0]);
				we_nxt = 1'b1;
			end
			`BFO_OP_ROR: begin
				res_nxt = {cz, op_data[7:1]};
				flg_nxt = zn_fix(flg_nxt, res_nxt, op_data[0], cz ^ op_data[0]);
				we_nxt = 1'b1;
			end
			`BFO_OP_ASR: begin
				res_nxt = {op_data[7], op_data[7:1]};
				flg_nxt = zn_fix(flg_nxt, res_nxt, op_data[0], op_data[7] ^ op_data[0]);
				we_nxt = 1'b1;
			end
			`BFO_OP_SWAP: begin
				res_nxt = {op_data[3:0], op_data[7:4]};
				we_nxt = 1'b1;
			end

			// Bit moves; the byte is written back whole, except BST, which writes only the T flag
			`BFO_OP_SBI: begin
				res_nxt = bit_put(op_data, op_bit, 1'b1);
				we_nxt = 1'b1;
			end
			`BFO_OP_CBI: begin
				res_nxt = bit_put(op_data, op_bit, 1'b0);
				we_nxt = 1'b1;
			end
			`BFO_OP_BST: begin
				flg_nxt = bit_put(status_flags_register_r, `BFO_FLAG_T, op_data[op_bit]);
			end
			`BFO_OP_BLD: begin
				res_nxt = bit_put(op_data, op_bit, status_flags_register_r[`BFO_FLAG_T]);
				we_nxt = 1'b1;
			end

			// Flag writes; one index covers every single-flag op
			`BFO_OP_BSET: begin
				flg_nxt = bit_put(status_flags_register_r, op_bit, 1'b1);
			end
			`BFO_OP_BCLR: begin
				flg_nxt = bit_put(status_flags_register_r, op_bit, 1'b0);
			end
			default: begin
				res_nxt = op_data;
			end
		endcase
	end

	always @(posedge clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
			wait_cnt_r <= 4'h0;
			result_r <= 8'h00;
			result_we_r <= 1'b0;
			status_flags_register_r <= `BFO_FLAGS_RESET;
			mem_done_r <= 1'b0;
		end else if (ce) begin
			result_we_r <= 1'b0;
			mem_done_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (take) begin
						if (op_code == `BFO_OP_MEM) begin
							// Internal RAM keeps the listed timing
							if (mem_is_nvm) begin
								state_r <= ST_NVM;
								wait_cnt_r <= NVM_EXTRA;
							end else begin
								mem_done_r <= 1'b1;
							end
						end else begin
							result_r <= res_nxt;
							result_we_r <= we_nxt;
							// Break and the unit ops leave flg_nxt equal to the flags
							status_flags_register_r <= flg_nxt;
						end
					end
				end
				ST_NVM: begin
					// Minimum extra count runs down first, then waits out busy and contention
					if (wait_cnt_r != 4'h0) begin
						wait_cnt_r <= wait_cnt_r - 4'h1;
					end else if (!nvm_busy && !nvm_contend) begin
						state_r <= ST_IDLE;
						mem_done_r <= 1'b1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Unit strobes are kept apart but still need op_ready, so a stalled access delays them
	always @(posedge clk) begin
		if (srst) begin
			break_req_r <= 1'b0;
			sleep_req_r <= 1'b0;
			wdr_req_r <= 1'b0;
		end else if (ce) begin
			break_req_r <= hit(take, op_code, `BFO_OP_BREAK);
			sleep_req_r <= hit(take, op_code, `BFO_OP_SLEEP);
			wdr_req_r <= hit(take, op_code, `BFO_OP_WDR);
		end
	end

endmodule // bfo_core

// >>> bfo_core_monitor.sv
`timescale 1ns/1ps
`include "bfo_defines.vh"
module bfo_core_monitor (
	// Clock and control
	input wire clk,
	input wire srst,
	input wire ce,
	// Decoded instruction
	input wire op_valid,
	input wire [4:0] op_code,
	input wire [7:0] op_data,
	input wire [2:0] op_bit,
	input wire mem_is_nvm,
	input wire nvm_busy,
	input wire nvm_contend,
	// Results
	input wire op_ready,
	input wire [7:0] result_r,
	input wire result_we_r,
	input wire [7:0] status_flags_register_r,
	input wire mem_done_r,
	input wire break_req_r,
	input wire sleep_req_r
);
	wire tk = ce && op_valid && op_ready;
	wire [7:0] f = status_flags_register_r;
	wire [7:0] sw = {op_data[3:0], op_data[7:4]};
	wire mem = tk && op_code == `BFO_OP_MEM;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_break_one: assert property (tk && op_code == `BFO_OP_BREAK |=> break_req_r && f == $past(f))
		else $error("break pulse or flags wrong");
	a_half_set: assert property (tk && op_code == `BFO_OP_BSET && op_bit == 3'h5 |=> f == ($past(f) | 8'h20))
		else $error("half carry set wrong");
	a_half_clear: assert property (tk && op_code == `BFO_OP_BCLR && op_bit == 3'h5 |=> f == ($past(f) & 8'hDF))
		else $error("half carry clear wrong");
	a_ram_fast: assert property (mem && !mem_is_nvm |=> mem_done_r)
		else $error("internal memory access slow");
	a_nvm_extra: assert property (mem && mem_is_nvm |=> !mem_done_r [*2])
		else $error("nonvolatile access too fast");
	a_nvm_stall: assert property (ce && !op_ready && (nvm_busy || nvm_contend) |=> !mem_done_r)
		else $error("access ended while stalled");
	a_swap_one: assert property (tk && op_code == `BFO_OP_SWAP |=> result_we_r && result_r == $past(sw) && f == $past(f))
		else $error("swap wrong");
	a_sleep_one: assert property (tk && op_code == `BFO_OP_SLEEP |=> sleep_req_r && f == $past(f))
		else $error("sleep wrong");
endmodule // bfo_core_monitor
bind bfo_core bfo_core_monitor mon (.*);

// >>> bfo_nvm_model.sv
`timescale 1ns/1ps
module bfo_nvm_model (
	// Clock and access start
	input wire clk,
	input wire go,
	// Stall status
	output wire busy,
	output wire contend
);
	reg [2:0] cnt_r = 3'h0;
	always @(posedge clk) cnt_r <= go ? 3'h4 : cnt_r - {2'h0, cnt_r != 3'h0};
	// Controller busy first, then another master holds the memory
	assign busy = cnt_r > 3'h2;
	assign contend = cnt_r == 3'h1 || cnt_r == 3'h2;
endmodule // bfo_nvm_model

// >>> bfo_core_tb.sv
`timescale 1ns/1ps
`include "bfo_defines.vh"
module bfo_core_tb;
	reg clk = 1'b0;
	reg srst = 1'b1;
	reg op_valid = 1'b0;
	reg [4:0] op_code = 5'h00;
	reg [7:0] op_data = 8'h00;
	reg [2:0] op_bit = 3'h0;
	reg mem_is_nvm = 1'b0;
	reg ce = 1'b1;
	wire nvm_busy, nvm_contend, op_ready, result_we_r, mem_done_r, break_req_r;
	wire sleep_req_r, wdr_req_r;
	wire [7:0] result_r, flags;
	integer err_count = 0;
	integer n_checks = 0;
	integer n;
	initial begin
		forever #25 clk = ~clk;
	end
	bfo_core dut (.clk(clk), .srst(srst), .ce(ce), .op_valid(op_valid), .op_code(op_code),
		.op_data(op_data), .op_bit(op_bit), .mem_is_nvm(mem_is_nvm), .nvm_busy(nvm_busy),
		.nvm_contend(nvm_contend), .op_ready(op_ready), .result_r(result_r),
		.result_we_r(result_we_r), .status_flags_register_r(flags), .mem_done_r(mem_done_r),
		.break_req_r(break_req_r), .sleep_req_r(sleep_req_r), .wdr_req_r(wdr_req_r));
	bfo_nvm_model nvm (.clk(clk), .go(op_valid && op_code == `BFO_OP_MEM && mem_is_nvm && op_ready),
		.busy(nvm_busy), .contend(nvm_contend));
	task final_report;
	begin
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task ck(input [7:0] g, input [7:0] e);
	begin
		n_checks = n_checks + 1;
		if (g !== e) begin
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
			err_count = err_count + 1;
		end
	end
	endtask
	// One idle cycle between ops keeps each input to one change per step
	task op(input [4:0] c, input [7:0] d, input [2:0] b);
	begin
		@(posedge clk);
		#1 op_code = c;
		op_data = d;
		op_bit = b;
		op_valid = 1'b1;
		@(posedge clk);
		#1 op_valid = 1'b0;
	end
	endtask
	task t_shift;
	begin
		op(`BFO_OP_LSL, 8'h81, 3'h0);
		ck(result_r, 8'h02);
		ck(flags, 8'h19);
		$display("shift test done");
	end
	endtask
	task t_break;
	begin
		op(`BFO_OP_BREAK, 8'hFF, 3'h7);
		ck({7'h00, break_req_r}, 8'h01);
		ck(flags, 8'h19);
		$display("break test done");
	end
	endtask
	task t_half;
	begin
		op(`BFO_OP_BSET, 8'h00, 3'h5);
		ck(flags, 8'h39);
		op(`BFO_OP_BCLR, 8'h00, 3'h5);
		ck(flags, 8'h19);
		$display("half carry test done");
	end
	endtask
	task t_swap;
	begin
		op(`BFO_OP_SWAP, 8'hA5, 3'h0);
		ck(result_r, 8'h5A);
		ck({7'h00, result_we_r}, 8'h01);
		ck(flags, 8'h19);
		$display("swap test done");
	end
	endtask
	task t_hold;
	begin
		ce = 1'b0;
		op(`BFO_OP_LSL, 8'hFF, 3'h0);
		ck(result_r, 8'h5A);
		ck(flags, 8'h19);
		ce = 1'b1;
		$display("clock enable hold test done");
	end
	endtask
	task t_units;
	begin
		op(`BFO_OP_SLEEP, 8'h00, 3'h0);
		ck({7'h00, sleep_req_r}, 8'h01);
		op(`BFO_OP_WDR, 8'h00, 3'h0);
		ck({6'h00, wdr_req_r, sleep_req_r}, 8'h02);
		op(`BFO_OP_BST, 8'h40, 3'h6);
		ck(flags, 8'h59);
		op(`BFO_OP_BLD, 8'h00, 3'h0);
		ck(result_r, 8'h01);
		ck(flags, 8'h59);
		$display("unit and bit test done");
	end
	endtask
	task t_mem;
	begin
		op(`BFO_OP_MEM, 8'h00, 3'h0);
		ck({7'h00, mem_done_r}, 8'h01);
		mem_is_nvm = 1'b1;
		op(`BFO_OP_MEM, 8'h00, 3'h0);
		n = 0;
		while (!mem_done_r && n < 20) begin
			@(posedge clk);
			#1 n = n + 1;
		end
		ck({3'h0, n[4:0]}, 8'h05);
		if (n == 20) begin
			err_count = err_count + 1;
			final_report;
		end
		$display("memory test done");
	end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#1 srst = 1'b0;
		t_shift;
		t_break;
		t_half;
		t_swap;
		t_hold;
		t_units;
		t_mem;
		final_report;
	end
endmodule // bfo_core_tb
